//--- bench/asp_drv_model.sv
/*
 * Line driver input model: rebuilds words from the two digital outputs.
 * Assumes a null half between bits, so each data half starts fresh.
 */
`default_nettype none

module asp_drv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pos_i,
  input wire logic neg_i,
  output logic [31:0] word_o,
  output logic [5:0] bits_o
);
  logic act_r;
  always_ff @(posedge clk_i) begin
    act_r <= pos_i | neg_i;
    if (rst_i) begin
      word_o <= '0;
      bits_o <= '0;
    end else if ((pos_i | neg_i) && !act_r && bits_o != 6'h20) begin
      word_o <= {pos_i, word_o[31:1]};
      bits_o <= bits_o + 6'h01;
    end
  end
endmodule : asp_drv_model

`default_nettype wire

//--- bench/asp_monitor.sv
/*
 * Concurrent checks on the pins of the ARINC status and output block.
 * Assumes one system clock and a synchronous active high reset.
 */
`default_nettype none

module asp_monitor
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [asp_pkg::ASP_AW-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic master_clear_input_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_so_o,
  input wire logic [5:0] rx_mailbox_load_i,
  input wire logic rx_fifo_clear_o,
  input wire logic rx1_mailbox1_ready_o,
  input wire logic rx2_mailbox1_ready_o,
  input wire logic tx_fifo_empty_out_o,
  input wire logic tx_fifo_full_out_o,
  input wire logic tx_digital_pos_o,
  input wire logic tx_digital_neg_o,
  input wire logic tx_speed_select_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Clear pin quiet long enough for its synchronizer to be flushed
  sequence s_no_clr;
    !master_clear_input_i && !$past(master_clear_input_i) && !$past(master_clear_input_i, 2) && !rx_fifo_clear_o;
  endsequence
  sequence s_clr_held;
    master_clear_input_i [*6];
  endsequence

  property p_ack_resp; s_req |=> wb_ack_o; endproperty
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_clear;
    s_clr_held |-> rx_fifo_clear_o && tx_fifo_empty_out_o && !tx_fifo_full_out_o
      && !rx1_mailbox1_ready_o && !tx_digital_pos_o && !tx_digital_neg_o;
  endproperty
  property p_so_idle; spi_cs_n_i [*5] |-> !spi_so_o; endproperty
  property p_mbox1; (rx_mailbox_load_i[0] and s_no_clr) |=> rx1_mailbox1_ready_o; endproperty
  property p_mbox2; (rx_mailbox_load_i[3] and s_no_clr) |=> rx2_mailbox1_ready_o; endproperty
  property p_levels; !(tx_fifo_empty_out_o && tx_fifo_full_out_o); endproperty
  property p_halves; !(tx_digital_pos_o && tx_digital_neg_o); endproperty
  property p_speed;
    $changed(tx_speed_select_out_o) |-> $past(wb_ack_o) && $past(wb_we_i) && ($past(wb_adr_i) == ASP_OFS_CTRL);
  endproperty

  a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_clear: assert property (p_clear) else $error("master clear left state behind");
  a_so_idle: assert property (p_so_idle) else $error("serial out driven while deselected");
  a_mbox1: assert property (p_mbox1) else $error("rx1 mailbox1 not shown");
  a_mbox2: assert property (p_mbox2) else $error("rx2 mailbox1 not shown");
  a_levels: assert property (p_levels) else $error("empty and full together");
  a_halves: assert property (p_halves) else $error("both transmit outputs high");
  a_speed: assert property (p_speed) else $error("speed select moved without control write");
endmodule : asp_monitor

bind asp_top asp_monitor u_asp_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
  .master_clear_input_i, .spi_cs_n_i, .spi_so_o, .rx_mailbox_load_i, .rx_fifo_clear_o, .rx1_mailbox1_ready_o,
  .rx2_mailbox1_ready_o, .tx_fifo_empty_out_o, .tx_fifo_full_out_o, .tx_digital_pos_o, .tx_digital_neg_o,
  .tx_speed_select_out_o);

`default_nettype wire

//--- bench/testbench.sv
/*
 * Self-checking bench for the ARINC status and output block.
 * Assumes the bound monitor and the line driver model beside it.
 */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, master_clear_input_i, arinc_clk_i;
  logic [ASP_AW-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [ASP_DW-1:0] wb_dat_i, wb_dat_o, rd, rx_word;
  logic spi_cs_n_i, spi_sclk_i, spi_si_i, spi_so_o, rx_fifo_clear_o, irq_o;
  logic [5:0] rx_mailbox_load_i, rx_bits;
  logic [1:0] rx_fifo_nempty_i, rx_fifo_half_i, rx_fifo_full_i;
  logic rx1_mailbox1_ready_o, rx1_mailbox2_ready_o, rx1_mailbox3_ready_o;
  logic rx2_mailbox1_ready_o, rx2_mailbox2_ready_o, rx2_mailbox3_ready_o;
  logic rx1_interrupt_out_o, rx2_interrupt_out_o, rx1_flag_out_o, rx2_flag_out_o;
  logic tx_fifo_empty_out_o, tx_fifo_full_out_o, tx_digital_pos_o, tx_digital_neg_o, tx_speed_select_out_o;
  int num_errors, cmp_count;

  asp_top u_asp_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .master_clear_input_i, .arinc_clk_i, .spi_cs_n_i, .spi_sclk_i, .spi_si_i, .spi_so_o,
    .rx_mailbox_load_i, .rx_fifo_nempty_i, .rx_fifo_half_i, .rx_fifo_full_i, .rx_fifo_clear_o,
    .rx1_mailbox1_ready_o, .rx1_mailbox2_ready_o, .rx1_mailbox3_ready_o, .rx2_mailbox1_ready_o,
    .rx2_mailbox2_ready_o, .rx2_mailbox3_ready_o, .rx1_interrupt_out_o, .rx2_interrupt_out_o, .rx1_flag_out_o,
    .rx2_flag_out_o, .tx_fifo_empty_out_o, .tx_fifo_full_out_o, .tx_digital_pos_o, .tx_digital_neg_o,
    .tx_speed_select_out_o, .irq_o);
  asp_drv_model u_asp_drv_model (.clk_i, .rst_i, .pos_i(tx_digital_pos_o), .neg_i(tx_digital_neg_o),
    .word_o(rx_word), .bits_o(rx_bits));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Odd offset keeps the link clock out of phase with the system clock
  initial begin
    arinc_clk_i = 1'b0;
    #3;
    forever #80 arinc_clk_i = ~arinc_clk_i;
  end

  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    // Ack and read data are taken at the edge that samples ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(ZERO, ONE);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, ZERO);
    chk(rd, exp);
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic mclear;
    @(posedge clk_i);
    master_clear_input_i <= 1'b1;
    settle(6);
    chk(32'(rx_fifo_clear_o), ONE);
    @(posedge clk_i);
    master_clear_input_i <= 1'b0;
    settle(4);
  endtask : mclear

  task automatic t_reset;
    settle(0);
    chk(32'({tx_fifo_empty_out_o, tx_fifo_full_out_o, tx_speed_select_out_o, irq_o}), 32'h0000_0008);
    rdc(ASP_OFS_FLAGASG, ZERO);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, ZERO);
    for (int i = 1; i >= 0; i--) begin
      wb(1'b1, ASP_OFS_CTRL, 32'(i));
      settle(1);
      chk(32'(tx_speed_select_out_o), 32'(i));
      rdc(ASP_OFS_CTRL, 32'(i));
    end
  endtask : t_reset

  task automatic t_fill;
    for (int i = 0; i < 33; i++) begin
      wb(1'b1, ASP_OFS_TXDATA, 32'(i));
      settle(1);
      chk(32'({tx_fifo_empty_out_o, tx_fifo_full_out_o}), (i >= 31) ? ONE : ZERO);
    end
    rdc(ASP_OFS_STATUS, 32'h0000_0220);
    mclear();
    chk(32'({tx_fifo_empty_out_o, tx_fifo_full_out_o}), 32'h0000_0002);
    rdc(ASP_OFS_STATUS, 32'h0000_0100);
  endtask : t_fill

  task automatic t_send;
    int n;
    wb(1'b1, ASP_OFS_IRQEN, ONE);
    wb(1'b1, ASP_OFS_CTRL, 32'h0000_0002);
    wb(1'b1, ASP_OFS_TXDATA, 32'h8123_4A5C);
    n = 0;
    while (irq_o !== 1'b1 && n < 20000) begin
      settle(0);
      n++;
    end
    chk(32'(irq_o), ONE);
    chk(rx_word, 32'h8123_4A5C);
    chk(32'(tx_fifo_empty_out_o), ONE);
    rdc(ASP_OFS_IRQSTAT, 32'h0000_0003);
    wb(1'b1, ASP_OFS_IRQCLR, ONE);
    settle(2);
    chk(32'(irq_o), ZERO);
    rdc(ASP_OFS_IRQSTAT, 32'h0000_0002);
    wb(1'b1, ASP_OFS_IRQCLR, 32'h0000_000F);
    wb(1'b1, ASP_OFS_CTRL, ZERO);
  endtask : t_send

  task automatic t_flags;
    wb(1'b1, ASP_OFS_FLAGASG, 32'h0000_006C);
    rdc(ASP_OFS_FLAGASG, 32'h0000_006C);
    @(posedge clk_i);
    // Rx2 not-empty stays low so a wrong selector shows
    {rx_fifo_nempty_i, rx_fifo_half_i, rx_fifo_full_i} <= 6'h1A;
    settle(2);
    chk(32'({rx1_flag_out_o, rx1_interrupt_out_o, rx2_flag_out_o, rx2_interrupt_out_o}), 32'h0000_000B);
    @(posedge clk_i);
    rx_mailbox_load_i <= 6'h29;
    @(posedge clk_i);
    rx_mailbox_load_i <= 6'h00;
    settle(1);
    chk(32'({rx2_mailbox3_ready_o, rx2_mailbox2_ready_o, rx2_mailbox1_ready_o, rx1_mailbox3_ready_o,
      rx1_mailbox2_ready_o, rx1_mailbox1_ready_o}), 32'h0000_0029);
    chk(32'(rx1_interrupt_out_o), ONE);
    rdc(ASP_OFS_STATUS, 32'h0000_A500);
    @(posedge clk_i);
    {rx_fifo_nempty_i, rx_fifo_half_i, rx_fifo_full_i} <= 6'h00;
    mclear();
    rdc(ASP_OFS_STATUS, 32'h0000_0100);
    chk(32'({rx1_interrupt_out_o, rx2_interrupt_out_o, rx1_flag_out_o, rx2_flag_out_o}), ZERO);
  endtask : t_flags

  task automatic t_spi;
    logic [7:0] tx;
    logic [7:0] rx;
    tx = 8'hA5;
    rx = 8'h3C;
    wb(1'b1, ASP_OFS_SPI, 32'(tx));
    @(posedge clk_i);
    spi_cs_n_i <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      @(posedge clk_i);
      spi_si_i <= rx[b];
      settle(5);
      chk(32'(spi_so_o), 32'(tx[b]));
      @(posedge clk_i);
      spi_sclk_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      spi_sclk_i <= 1'b0;
    end
    settle(6);
    @(posedge clk_i);
    spi_cs_n_i <= 1'b1;
    rdc(ASP_OFS_SPI, 32'(rx));
    rdc(ASP_OFS_IRQSTAT, 32'h0000_0004);
    chk(32'(spi_so_o), ZERO);
  endtask : t_spi

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hF};
    {master_clear_input_i, spi_sclk_i, spi_si_i, spi_cs_n_i} = 4'h1;
    {rx_mailbox_load_i, rx_fifo_nempty_i, rx_fifo_half_i, rx_fifo_full_i} = 12'h000;
    num_errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fill();
    t_send();
    t_flags();
    t_spi();
    final_report();
  end

  initial begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule : testbench

`default_nettype wire

//--- rtl/asp_pkg.sv
/*
 * Shared constants and types for the ARINC status and pin-output block.
 * Assumes a 125 MHz system clock and a Wishbone classic register bus.
 */
`default_nettype none

package asp_pkg;
  localparam int ASP_DW = 32;
  localparam int ASP_AW = 8;
  // Register byte offsets
  localparam logic [7:0] ASP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ASP_OFS_TXDATA = 8'h04;
  localparam logic [7:0] ASP_OFS_STATUS = 8'h08;
  localparam logic [7:0] ASP_OFS_FLAGASG = 8'h0C;
  localparam logic [7:0] ASP_OFS_MBCLR = 8'h10;
  localparam logic [7:0] ASP_OFS_IRQSTAT = 8'h14;
  localparam logic [7:0] ASP_OFS_IRQCLR = 8'h18;
  localparam logic [7:0] ASP_OFS_IRQEN = 8'h1C;
  localparam logic [7:0] ASP_OFS_SPI = 8'h20;
  // Control fields
  localparam int ASP_CTRL_RATE = 0;
  localparam int ASP_CTRL_TXEN = 1;
  localparam logic [1:0] ASP_CTRL_RST = 2'h0;
  localparam logic [7:0] ASP_FLAGASG_RST = 8'h00;
  localparam logic [7:0] ASP_SPI_TX_RST = 8'h00;
  // Interrupt status bit positions
  localparam int ASP_IRQ_N = 4;
  localparam int ASP_IRQ_TX_SENT = 0;
  localparam int ASP_IRQ_TX_EMPTY = 1;
  localparam int ASP_IRQ_SPI_BYTE = 2;
  localparam int ASP_IRQ_MBOX = 3;
  // Transmit FIFO
  localparam int ASP_TX_DEPTH = 32;
  localparam int ASP_TX_PTR_W = 5;
  localparam int ASP_TX_CNT_W = 6;
  localparam logic [5:0] ASP_TX_FULL_CNT = 6'h20;
  // Serializer timing in rising link clock edges
  localparam logic [7:0] ASP_HALF_HI = 8'h05;
  localparam logic [7:0] ASP_HALF_LO = 8'h28;
  localparam logic [5:0] ASP_LAST_BIT = 6'h1F;
  localparam logic [3:0] ASP_GAP_HALVES = 4'h8;

  typedef enum logic [1:0] {ASP_TX_IDLE, ASP_TX_BITS, ASP_TX_GAP} asp_tx_state_t;
  typedef enum logic [1:0] {ASP_SEL_NEMPTY, ASP_SEL_HALF, ASP_SEL_FULL, ASP_SEL_MBOX} asp_sel_t;
endpackage : asp_pkg

`default_nettype wire

//--- rtl/asp_top.sv
/*
 * Pin-level status, transmit FIFO and output logic of a dual receiver,
 * single transmitter ARINC controller with a Wishbone register port.
 * Assumes receive logic on the same clock supplies FIFO levels and
 * mailbox load pulses; pin inputs are asynchronous.
 */
// Decided for this implementation: the Wishbone register port and the register addresses.
`default_nettype none

module asp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [asp_pkg::ASP_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [asp_pkg::ASP_DW-1:0] wb_dat_i,
  output logic [asp_pkg::ASP_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_clear_input_i,
  input wire logic arinc_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  input wire logic [5:0] rx_mailbox_load_i,
  input wire logic [1:0] rx_fifo_nempty_i,
  input wire logic [1:0] rx_fifo_half_i,
  input wire logic [1:0] rx_fifo_full_i,
  output logic rx_fifo_clear_o,
  output logic rx1_mailbox1_ready_o,
  output logic rx1_mailbox2_ready_o,
  output logic rx1_mailbox3_ready_o,
  output logic rx2_mailbox1_ready_o,
  output logic rx2_mailbox2_ready_o,
  output logic rx2_mailbox3_ready_o,
  output logic rx1_interrupt_out_o,
  output logic rx2_interrupt_out_o,
  output logic rx1_flag_out_o,
  output logic rx2_flag_out_o,
  output logic tx_fifo_empty_out_o,
  output logic tx_fifo_full_out_o,
  output logic tx_digital_pos_o,
  output logic tx_digital_neg_o,
  output logic tx_speed_select_out_o,
  output logic irq_o
);
  import asp_pkg::*;

  function automatic logic sel_cond(input logic [1:0] sel, input logic nempty, input logic half,
                                    input logic full, input logic mbox);
    case (asp_sel_t'(sel))
      ASP_SEL_NEMPTY: sel_cond = nempty;
      ASP_SEL_HALF: sel_cond = half;
      ASP_SEL_FULL: sel_cond = full;
      default: sel_cond = mbox;
    endcase
  endfunction : sel_cond

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    byte_merge = (old & ~m) | (nw & m);
  endfunction : byte_merge

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] mc_sync_r;
  logic [2:0] ac_sync_r;
  logic [2:0] cs_sync_r;
  logic [2:0] sck_sync_r;
  logic [1:0] si_sync_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mc_sync_r <= 3'h0;
      ac_sync_r <= 3'h0;
      cs_sync_r <= 3'h7;
      sck_sync_r <= 3'h0;
      si_sync_r <= 2'h0;
    end else begin
      mc_sync_r <= {mc_sync_r[1:0], master_clear_input_i};
      ac_sync_r <= {ac_sync_r[1:0], arinc_clk_i};
      cs_sync_r <= {cs_sync_r[1:0], spi_cs_n_i};
      sck_sync_r <= {sck_sync_r[1:0], spi_sclk_i};
      si_sync_r <= {si_sync_r[0], spi_si_i};
    end
  end

  // Master clear acts for as long as the pin is high
  wire mclr = mc_sync_r[1];
  wire clr_all = rst_i || mclr;
  wire aclk_tick = ac_sync_r[1] && !ac_sync_r[2];
  wire cs_low = !cs_sync_r[1];
  wire cs_fall = !cs_sync_r[1] && cs_sync_r[2];
  wire sck_rise = sck_sync_r[1] && !sck_sync_r[2];
  wire sck_fall = !sck_sync_r[1] && sck_sync_r[2];

  // Wishbone decode; writes land on the acknowledging edge
  logic ack_r;
  logic [31:0] dat_r;
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_wr = wb_req && wb_we_i && ack_r;
  wire hit_ctrl = wb_adr_i == ASP_OFS_CTRL;
  wire hit_txdata = wb_adr_i == ASP_OFS_TXDATA;
  wire hit_status = wb_adr_i == ASP_OFS_STATUS;
  wire hit_flagasg = wb_adr_i == ASP_OFS_FLAGASG;
  wire hit_mbclr = wb_adr_i == ASP_OFS_MBCLR;
  wire hit_irqstat = wb_adr_i == ASP_OFS_IRQSTAT;
  wire hit_irqclr = wb_adr_i == ASP_OFS_IRQCLR;
  wire hit_irqen = wb_adr_i == ASP_OFS_IRQEN;
  wire hit_spi = wb_adr_i == ASP_OFS_SPI;
  wire [31:0] wdat = byte_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // Control and status state
  logic [1:0] ctrl_r;
  logic [7:0] flag_asg_r;
  logic [5:0] mbox_r;
  logic [ASP_IRQ_N-1:0] irq_stat_r;
  logic [ASP_IRQ_N-1:0] irq_en_r;
  logic irq_r;
  logic [7:0] spi_tx_r;
  logic [7:0] spi_rx_r;
  logic [7:0] spi_sh_r;
  logic [7:0] spi_out_r;
  logic [2:0] spi_bit_r;
  logic spi_so_r;
  logic rx_clr_r;
  logic [3:0] flags_r;

  // Transmit FIFO
  logic [31:0] tx_mem [0:ASP_TX_DEPTH-1];
  logic [ASP_TX_PTR_W-1:0] wr_ptr_r;
  logic [ASP_TX_PTR_W-1:0] rd_ptr_r;
  logic [ASP_TX_CNT_W-1:0] tx_cnt_r;
  logic tx_empty_r;
  logic tx_full_r;

  asp_tx_if txb ();

  // Words written while full are dropped
  wire tx_push = wb_wr && hit_txdata && (tx_cnt_r != ASP_TX_FULL_CNT);
  wire tx_pop = txb.take;
  wire [ASP_TX_CNT_W-1:0] tx_cnt_nxt = tx_cnt_r + {5'h00, tx_push} - {5'h00, tx_pop};

  assign txb.word = tx_mem[rd_ptr_r];
  assign txb.valid = (tx_cnt_r != 6'h00) && ctrl_r[ASP_CTRL_TXEN];
  assign txb.tick = aclk_tick;
  assign txb.rate = ctrl_r[ASP_CTRL_RATE];
  assign txb.clear = mclr;

  asp_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(txb.tx)
  );

  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      tx_mem[wr_ptr_r] <= wdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      tx_cnt_r <= '0;
      tx_empty_r <= 1'b1;
      tx_full_r <= 1'b0;
    end else begin
      if (tx_push) begin
        wr_ptr_r <= wr_ptr_r + 5'h01;
      end
      if (tx_pop) begin
        rd_ptr_r <= rd_ptr_r + 5'h01;
      end
      tx_cnt_r <= tx_cnt_nxt;
      tx_empty_r <= tx_cnt_nxt == 6'h00;
      tx_full_r <= tx_cnt_nxt == ASP_TX_FULL_CNT;
    end
  end

  // Hardware sets win over software clears
  wire spi_done = cs_low && sck_rise && (spi_bit_r == 3'h7);
  wire [ASP_IRQ_N-1:0] irq_ev = {|rx_mailbox_load_i, spi_done,
                                 tx_pop && (tx_cnt_r == 6'h01) && !tx_push, txb.done};
  wire [ASP_IRQ_N-1:0] irq_clr = (wb_wr && hit_irqclr) ? wdat[ASP_IRQ_N-1:0] : '0;
  wire [5:0] mb_clr = (wb_wr && hit_mbclr) ? wdat[5:0] : 6'h00;

  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      mbox_r <= 6'h00;
      irq_stat_r <= '0;
      rx_clr_r <= mclr;
    end else begin
      mbox_r <= (mbox_r & ~mb_clr) | rx_mailbox_load_i;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      rx_clr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= ASP_CTRL_RST;
      flag_asg_r <= ASP_FLAGASG_RST;
      irq_en_r <= '0;
      spi_tx_r <= ASP_SPI_TX_RST;
    end else if (wb_wr) begin
      if (hit_ctrl) begin
        ctrl_r <= wdat[1:0];
      end
      if (hit_flagasg) begin
        flag_asg_r <= wdat[7:0];
      end
      if (hit_irqen) begin
        irq_en_r <= wdat[ASP_IRQ_N-1:0];
      end
      if (hit_spi) begin
        spi_tx_r <= wdat[7:0];
      end
    end
  end

  // Flag and interrupt pins per receiver
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      flags_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      flags_r[0] <= sel_cond(flag_asg_r[1:0], rx_fifo_nempty_i[0], rx_fifo_half_i[0],
                             rx_fifo_full_i[0], |mbox_r[2:0]);
      flags_r[1] <= sel_cond(flag_asg_r[3:2], rx_fifo_nempty_i[0], rx_fifo_half_i[0],
                             rx_fifo_full_i[0], |mbox_r[2:0]);
      flags_r[2] <= sel_cond(flag_asg_r[5:4], rx_fifo_nempty_i[1], rx_fifo_half_i[1],
                             rx_fifo_full_i[1], |mbox_r[5:3]);
      flags_r[3] <= sel_cond(flag_asg_r[7:6], rx_fifo_nempty_i[1], rx_fifo_half_i[1],
                             rx_fifo_full_i[1], |mbox_r[5:3]);
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // Serial port, mode 0, MSB first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spi_sh_r <= 8'h00;
      spi_out_r <= 8'h00;
      spi_bit_r <= 3'h0;
      spi_rx_r <= 8'h00;
      spi_so_r <= 1'b0;
    end else if (!cs_low) begin
      spi_so_r <= 1'b0;
    end else if (cs_fall) begin
      spi_out_r <= spi_tx_r;
      spi_bit_r <= 3'h0;
      spi_so_r <= spi_tx_r[7];
    end else if (sck_rise) begin
      spi_sh_r <= {spi_sh_r[6:0], si_sync_r[1]};
      spi_bit_r <= spi_bit_r + 3'h1;
      if (spi_bit_r == 3'h7) begin
        spi_rx_r <= {spi_sh_r[6:0], si_sync_r[1]};
      end
    end else if (sck_fall) begin
      spi_out_r <= {spi_out_r[6:0], 1'b0};
      spi_so_r <= spi_out_r[6];
    end
  end

  // Read mux; unmapped addresses read zero
  wire [31:0] status_w = {16'h0000, mbox_r, tx_full_r, tx_empty_r, 2'h0, tx_cnt_r};
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0000_0000, ctrl_r} :
    hit_status ? status_w :
    hit_flagasg ? {24'h00_0000, flag_asg_r} :
    hit_irqstat ? {28'h000_0000, irq_stat_r} :
    hit_irqen ? {28'h000_0000, irq_en_r} :
    hit_spi ? {24'h00_0000, spi_rx_r} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req && !ack_r;
      if (wb_req && !ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign spi_so_o = spi_so_r;
  assign rx_fifo_clear_o = rx_clr_r;
  assign rx1_mailbox1_ready_o = mbox_r[0];
  assign rx1_mailbox2_ready_o = mbox_r[1];
  assign rx1_mailbox3_ready_o = mbox_r[2];
  assign rx2_mailbox1_ready_o = mbox_r[3];
  assign rx2_mailbox2_ready_o = mbox_r[4];
  assign rx2_mailbox3_ready_o = mbox_r[5];
  assign rx1_flag_out_o = flags_r[0];
  assign rx1_interrupt_out_o = flags_r[1];
  assign rx2_flag_out_o = flags_r[2];
  assign rx2_interrupt_out_o = flags_r[3];
  assign tx_fifo_empty_out_o = tx_empty_r;
  assign tx_fifo_full_out_o = tx_full_r;
  assign tx_digital_pos_o = txb.pos;
  assign tx_digital_neg_o = txb.neg;
  assign tx_speed_select_out_o = ctrl_r[ASP_CTRL_RATE];
  assign irq_o = irq_r;
endmodule : asp_top

`default_nettype wire

//--- rtl/asp_tx.sv
/*
 * ARINC word serializer: return-to-zero bits on two digital outputs.
 * Assumes one tick per rising link clock edge and a word held while valid.
 */
`default_nettype none

module asp_tx (
  input wire logic clk_i,
  input wire logic rst_i,
  asp_tx_if.tx bus
);
  import asp_pkg::*;

  asp_tx_state_t state_r;
  logic [31:0] sh_r;
  logic [5:0] bit_r;
  logic phase_r;
  logic [7:0] tick_cnt_r;
  logic [3:0] gap_r;
  logic pos_r;
  logic neg_r;
  logic take_r;
  logic done_r;

  // Low speed when the rate bit is high
  wire [7:0] half_len = bus.rate ? ASP_HALF_LO : ASP_HALF_HI;
  wire half_end = bus.tick && (tick_cnt_r == half_len - 8'h01);

  assign bus.pos = pos_r;
  assign bus.neg = neg_r;
  assign bus.take = take_r;
  assign bus.done = done_r;

  always_ff @(posedge clk_i) begin
    take_r <= 1'b0;
    done_r <= 1'b0;
    if (rst_i || bus.clear) begin
      state_r <= ASP_TX_IDLE;
      sh_r <= 32'h0000_0000;
      bit_r <= 6'h00;
      phase_r <= 1'b0;
      tick_cnt_r <= 8'h00;
      gap_r <= 4'h0;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else begin
      if (bus.tick) begin
        tick_cnt_r <= half_end ? 8'h00 : tick_cnt_r + 8'h01;
      end
      case (state_r)
        ASP_TX_IDLE: begin
          if (bus.valid) begin
            sh_r <= bus.word;
            take_r <= 1'b1;
            bit_r <= 6'h00;
            phase_r <= 1'b0;
            tick_cnt_r <= 8'h00;
            pos_r <= bus.word[0];
            neg_r <= ~bus.word[0];
            state_r <= ASP_TX_BITS;
          end
        end
        ASP_TX_BITS: begin
          if (half_end) begin
            if (!phase_r) begin
              // Return to zero for the second half of each bit
              phase_r <= 1'b1;
              pos_r <= 1'b0;
              neg_r <= 1'b0;
            end else if (bit_r == ASP_LAST_BIT) begin
              done_r <= 1'b1;
              gap_r <= 4'h0;
              state_r <= ASP_TX_GAP;
            end else begin
              phase_r <= 1'b0;
              bit_r <= bit_r + 6'h01;
              sh_r <= {1'b0, sh_r[31:1]};
              pos_r <= sh_r[1];
              neg_r <= ~sh_r[1];
            end
          end
        end
        ASP_TX_GAP: begin
          if (half_end) begin
            if (gap_r == ASP_GAP_HALVES - 4'h1) begin
              state_r <= ASP_TX_IDLE;
            end else begin
              gap_r <= gap_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= ASP_TX_IDLE;
        end
      endcase
    end
  end
endmodule : asp_tx

`default_nettype wire

//--- rtl/asp_tx_if.sv
/*
 * Link between the register side and the ARINC word serializer.
 * Assumes both ends run on the same system clock.
 */
`default_nettype none

interface asp_tx_if;
  logic [31:0] word;
  logic valid;
  logic take;
  logic done;
  logic tick;
  logic rate;
  logic clear;
  logic pos;
  logic neg;
  modport src (output word, output valid, output tick, output rate, output clear,
               input take, input done, input pos, input neg);
  modport tx (input word, input valid, input tick, input rate, input clear,
              output take, output done, output pos, output neg);
endinterface : asp_tx_if

`default_nettype wire
